// ---- design/ulx_exec.sv ----
`timescale 1ns/10ps
module ulx_exec #(
   parameter int          REG_BYTES   = 128,
   parameter int          STACK_WORDS = 32,
   parameter logic [15:0] SP_RESET    = 16'h0040,
   parameter logic [15:0] PC_RESET    = 16'h0000
) (
   // clock and reset
   input  wire logic               clock,
   input  wire logic               sys_rst,
   // instruction stream
   input  wire logic               instr_valid,
   input  wire ulx_pkg::ulx_instr_t instr,
   output logic                    instr_ready,
   output logic                    instr_done,
   output logic                    irq_inhibit,
   // register port
   input  wire ulx_pkg::ulx_regbus_t regbus,
   output logic [15:0]             rd_data,
   // core state view
   output logic [15:0]             pc,
   output logic [15:0]             sp,
   output logic [7:0]              status_word
);

   localparam int RIW = $clog2(REG_BYTES);
   localparam int SIW = $clog2(STACK_WORDS);

   typedef enum logic [0:0] {S_IDLE, S_NORM} ulx_fsm_t;

   typedef struct packed {
      ulx_fsm_t                          fsm;
      logic [REG_BYTES-1:0][7:0]         regs;
      logic [STACK_WORDS-1:0][15:0]      stk;
      logic [15:0]                       sp;
      logic [15:0]                       pc;
      logic [7:0]                        status;
      logic [7:0]                        imask;
      logic [7:0]                        imask1;
      logic [7:0]                        wsel;
      logic [31:0]                       nlong;
      logic [4:0]                        ncnt;
      logic [7:0]                        nbreg;
      logic [7:0]                        nlreg;
      logic [15:0]                       nlen;
      logic                              ready;
      logic                              done;
      logic                              inhibit;
      logic [15:0]                       rdata;
   } ulx_state_t;

   ulx_state_t q_ff;
   ulx_state_t nxt_q;

   // ***************************************************************
   // helpers
   // ***************************************************************
   function automatic logic [RIW-1:0] ridx(input logic [7:0] a);
      ridx = a[RIW-1:0];
   endfunction : ridx

   function automatic logic [SIW-1:0] sidx(input logic [15:0] s);
      sidx = s[SIW:1];
   endfunction : sidx

   function automatic logic [15:0] rd_word(input logic [REG_BYTES-1:0][7:0] r, input logic [7:0] a);
      rd_word = {r[ridx(a + 8'h01)], r[ridx(a)]};
   endfunction : rd_word

   function automatic ulx_pkg::ulx_kind_t kind_of(input logic [7:0] op);
      logic [7:0] base;
      base = op & ulx_pkg::OP_MODE_MASK;
      if (op == ulx_pkg::OP_WORD_NEGATE) kind_of = ulx_pkg::K_WNEG;
      else if (op == ulx_pkg::OP_BYTE_NEGATE) kind_of = ulx_pkg::K_BNEG;
      else if (op == ulx_pkg::OP_LONG_NORMALIZE) kind_of = ulx_pkg::K_NORM;
      else if (op == ulx_pkg::OP_WORD_INVERT) kind_of = ulx_pkg::K_WINV;
      else if (op == ulx_pkg::OP_BYTE_INVERT) kind_of = ulx_pkg::K_BINV;
      else if (base == ulx_pkg::OP_WORD_OR) kind_of = ulx_pkg::K_WOR;
      else if (base == ulx_pkg::OP_BYTE_OR) kind_of = ulx_pkg::K_BOR;
      else if (base == ulx_pkg::OP_POP_WORD) kind_of = ulx_pkg::K_POP;
      else if (base == ulx_pkg::OP_PUSH_WORD) kind_of = ulx_pkg::K_PUSH;
      else if (op == ulx_pkg::OP_POP_ALL) kind_of = ulx_pkg::K_POPALL;
      else if (op == ulx_pkg::OP_PUSH_ALL) kind_of = ulx_pkg::K_PUSHALL;
      else if (op == ulx_pkg::OP_POP_FLAGS) kind_of = ulx_pkg::K_POPFLG;
      else if (op == ulx_pkg::OP_PUSH_FLAGS) kind_of = ulx_pkg::K_PUSHFLG;
      else if (op == ulx_pkg::OP_RETURN) kind_of = ulx_pkg::K_RETURN;
      else kind_of = ulx_pkg::K_NOP; // unknown codes behave as no-operation
   endfunction : kind_of

   // instruction length in bytes, so pc lands on the next opcode
   function automatic logic [15:0] len_of(input ulx_pkg::ulx_kind_t k, input logic imm);
      case (k)
         ulx_pkg::K_WNEG, ulx_pkg::K_BNEG,
         ulx_pkg::K_WINV, ulx_pkg::K_BINV: len_of = 16'h0002;
         ulx_pkg::K_NORM:                  len_of = 16'h0003;
         ulx_pkg::K_WOR:                   len_of = imm ? 16'h0004 : 16'h0003;
         ulx_pkg::K_BOR:                   len_of = 16'h0003;
         ulx_pkg::K_POP:                   len_of = 16'h0002;
         ulx_pkg::K_PUSH:                  len_of = imm ? 16'h0003 : 16'h0002;
         default:                          len_of = 16'h0001;
      endcase
   endfunction : len_of

   // arithmetic flag update; sticky bit always kept, trap bit only ever set
   function automatic logic [7:0] arith_flags(input logic [7:0] p, input logic z, input logic n,
                                              input logic c, input logic v);
      logic [7:0] r;
      r = p;
      r[ulx_pkg::FLAG_Z]  = z;
      r[ulx_pkg::FLAG_N]  = n;
      r[ulx_pkg::FLAG_C]  = c;
      r[ulx_pkg::FLAG_V]  = v;
      r[ulx_pkg::FLAG_TRAP] = p[ulx_pkg::FLAG_TRAP] | v;
      arith_flags = r;
   endfunction : arith_flags

   // logical result flags: carry and overflow cleared, trap and sticky kept
   function automatic logic [7:0] logic_flags(input logic [7:0] p, input logic z, input logic n);
      logic [7:0] r;
      r = p;
      r[ulx_pkg::FLAG_Z] = z;
      r[ulx_pkg::FLAG_N] = n;
      r[ulx_pkg::FLAG_C] = 1'b0;
      r[ulx_pkg::FLAG_V] = 1'b0;
      logic_flags = r;
   endfunction : logic_flags

   // ***************************************************************
   // next state
   // ***************************************************************
   // software writes land first so an executing instruction overrides them
   always_comb begin
      ulx_pkg::ulx_kind_t k;
      logic               imm_mode;
      logic [15:0]        w;
      logic [15:0]        src;
      logic [15:0]        res;
      logic [7:0]         b;
      logic [7:0]         rb;
      logic [15:0]        nsp;
      logic               fin;
      k        = kind_of(instr.opcode);
      imm_mode = instr.opcode[1:0] == ulx_pkg::MODE_IMMEDIATE;
      w        = 16'h0000;
      src      = 16'h0000;
      res      = 16'h0000;
      b        = 8'h00;
      rb       = 8'h00;
      nsp      = 16'h0000;
      fin      = 1'b0;
      nxt_q      = q_ff;
      nxt_q.done = 1'b0;

      // register port write
      if (regbus.wr) begin
         if (regbus.addr < ulx_pkg::ADDR_REG_LIMIT) begin
            nxt_q.regs[ridx(regbus.addr)]         = regbus.wdata[7:0];
            nxt_q.regs[ridx(regbus.addr + 8'h01)] = regbus.wdata[15:8];
         end else if (regbus.addr == ulx_pkg::ADDR_SP) begin
            nxt_q.sp = regbus.wdata;
         end else if (regbus.addr == ulx_pkg::ADDR_PC) begin
            nxt_q.pc = regbus.wdata;
         end else if (regbus.addr == ulx_pkg::ADDR_STATUS) begin
            {nxt_q.status, nxt_q.imask} = regbus.wdata;
         end else if (regbus.addr == ulx_pkg::ADDR_MASK1) begin
            {nxt_q.wsel, nxt_q.imask1} = regbus.wdata;
         end
      end

      // register port read, answered next cycle; unmapped reads zero
      if (regbus.rd) begin
         if (regbus.addr < ulx_pkg::ADDR_REG_LIMIT) nxt_q.rdata = rd_word(q_ff.regs, regbus.addr);
         else if (regbus.addr == ulx_pkg::ADDR_SP) nxt_q.rdata = q_ff.sp;
         else if (regbus.addr == ulx_pkg::ADDR_PC) nxt_q.rdata = q_ff.pc;
         else if (regbus.addr == ulx_pkg::ADDR_STATUS) nxt_q.rdata = {q_ff.status, q_ff.imask};
         else if (regbus.addr == ulx_pkg::ADDR_MASK1) nxt_q.rdata = {q_ff.wsel, q_ff.imask1};
         else if (regbus.addr == ulx_pkg::ADDR_STATE) nxt_q.rdata = {11'h000, q_ff.ncnt};
         else nxt_q.rdata = 16'h0000;
      end

      case (q_ff.fsm)
         S_IDLE: begin
            if (instr_valid) begin
               fin = 1'b1;
               nxt_q.nlen = len_of(k, imm_mode);
               w = rd_word(q_ff.regs, instr.opnd_a);
               b = q_ff.regs[ridx(instr.opnd_a)];
               case (k)
                  ulx_pkg::K_WNEG: begin
                     res = 16'h0000 - w;
                     nxt_q.regs[ridx(instr.opnd_a)]         = res[7:0];
                     nxt_q.regs[ridx(instr.opnd_a + 8'h01)] = res[15:8];
                     nxt_q.status = arith_flags(q_ff.status, res == 16'h0000, res[15],
                                             w == 16'h0000, w == 16'h8000);
                  end
                  ulx_pkg::K_BNEG: begin
                     rb = 8'h00 - b;
                     nxt_q.regs[ridx(instr.opnd_a)] = rb;
                     nxt_q.status = arith_flags(q_ff.status, rb == 8'h00, rb[7],
                                             b == 8'h00, b == 8'h80);
                  end
                  ulx_pkg::K_NORM: begin
                     // one shift per clock keeps the datapath to a single shifter
                     fin         = 1'b0;
                     nxt_q.fsm   = S_NORM;
                     nxt_q.nbreg = instr.opnd_a;
                     nxt_q.nlreg = instr.opnd_b;
                     nxt_q.ncnt  = 5'h00;
                     nxt_q.nlong = {rd_word(q_ff.regs, instr.opnd_b + 8'h02),
                                    rd_word(q_ff.regs, instr.opnd_b)};
                  end
                  ulx_pkg::K_WINV: begin
                     res = ~w;
                     nxt_q.regs[ridx(instr.opnd_a)]         = res[7:0];
                     nxt_q.regs[ridx(instr.opnd_a + 8'h01)] = res[15:8];
                     nxt_q.status = logic_flags(q_ff.status, res == 16'h0000, res[15]);
                  end
                  ulx_pkg::K_BINV: begin
                     rb = ~b;
                     nxt_q.regs[ridx(instr.opnd_a)] = rb;
                     nxt_q.status = logic_flags(q_ff.status, rb == 8'h00, rb[7]);
                  end
                  ulx_pkg::K_WOR: begin
                     src = imm_mode ? instr.imm : w;
                     res = rd_word(q_ff.regs, instr.opnd_b) | src;
                     nxt_q.regs[ridx(instr.opnd_b)]         = res[7:0];
                     nxt_q.regs[ridx(instr.opnd_b + 8'h01)] = res[15:8];
                     nxt_q.status = logic_flags(q_ff.status, res == 16'h0000, res[15]);
                  end
                  ulx_pkg::K_BOR: begin
                     rb = q_ff.regs[ridx(instr.opnd_b)] | (imm_mode ? instr.opnd_a : b);
                     nxt_q.regs[ridx(instr.opnd_b)] = rb;
                     nxt_q.status = logic_flags(q_ff.status, rb == 8'h00, rb[7]);
                  end
                  ulx_pkg::K_POP: begin
                     res = q_ff.stk[sidx(q_ff.sp)];
                     nxt_q.regs[ridx(instr.opnd_a)]         = res[7:0];
                     nxt_q.regs[ridx(instr.opnd_a + 8'h01)] = res[15:8];
                     nxt_q.sp = q_ff.sp + ulx_pkg::STACK_STEP;
                  end
                  ulx_pkg::K_PUSH: begin
                     nsp = q_ff.sp - ulx_pkg::STACK_STEP;
                     nxt_q.sp = nsp;
                     nxt_q.stk[sidx(nsp)] = imm_mode ? instr.imm : w;
                  end
                  ulx_pkg::K_POPALL: begin
                     {nxt_q.wsel, nxt_q.imask1}  = q_ff.stk[sidx(q_ff.sp)];
                     {nxt_q.status, nxt_q.imask} = q_ff.stk[sidx(q_ff.sp + ulx_pkg::STACK_STEP)];
                     nxt_q.sp = q_ff.sp + ulx_pkg::STACK_STEP + ulx_pkg::STACK_STEP;
                  end
                  ulx_pkg::K_PUSHALL: begin
                     // status pair deeper, mask pair on top, so pop-all undoes it
                     nsp = q_ff.sp - ulx_pkg::STACK_STEP;
                     nxt_q.stk[sidx(nsp)] = {q_ff.status, q_ff.imask};
                     nsp = nsp - ulx_pkg::STACK_STEP;
                     nxt_q.stk[sidx(nsp)] = {q_ff.wsel, q_ff.imask1};
                     nxt_q.sp     = nsp;
                     nxt_q.status = ulx_pkg::STATUS_CLEAR;
                  end
                  ulx_pkg::K_POPFLG: begin
                     {nxt_q.status, nxt_q.imask} = q_ff.stk[sidx(q_ff.sp)];
                     nxt_q.sp = q_ff.sp + ulx_pkg::STACK_STEP;
                  end
                  ulx_pkg::K_PUSHFLG: begin
                     nsp = q_ff.sp - ulx_pkg::STACK_STEP;
                     nxt_q.sp = nsp;
                     nxt_q.stk[sidx(nsp)] = {q_ff.status, q_ff.imask};
                     nxt_q.status = ulx_pkg::STATUS_CLEAR;
                  end
                  ulx_pkg::K_RETURN: begin
                     nxt_q.nlen = 16'h0000;
                     nxt_q.pc   = q_ff.stk[sidx(q_ff.sp)];
                     nxt_q.sp   = q_ff.sp + ulx_pkg::STACK_STEP;
                  end
                  default: begin
                     nxt_q.status = q_ff.status;
                  end
               endcase
               if (fin) begin
                  // a flag push or pop blocks interrupt calls across exactly one more instruction
                  nxt_q.inhibit = (k == ulx_pkg::K_POPFLG) | (k == ulx_pkg::K_PUSHFLG);
                  if (k != ulx_pkg::K_RETURN) nxt_q.pc = q_ff.pc + nxt_q.nlen;
               end
            end
         end
         S_NORM: begin
            if (!q_ff.nlong[31] && q_ff.ncnt != ulx_pkg::NORM_MAX) begin
               nxt_q.nlong = {q_ff.nlong[30:0], 1'b0};
               nxt_q.ncnt  = q_ff.ncnt + 5'h01;
            end else begin
               fin = 1'b1;
               nxt_q.fsm = S_IDLE;
               nxt_q.regs[ridx(q_ff.nlreg)]         = q_ff.nlong[7:0];
               nxt_q.regs[ridx(q_ff.nlreg + 8'h01)] = q_ff.nlong[15:8];
               nxt_q.regs[ridx(q_ff.nlreg + 8'h02)] = q_ff.nlong[23:16];
               nxt_q.regs[ridx(q_ff.nlreg + 8'h03)] = q_ff.nlong[31:24];
               nxt_q.regs[ridx(q_ff.nbreg)]         = {3'h0, q_ff.ncnt};
               nxt_q.status[ulx_pkg::FLAG_Z] = ~q_ff.nlong[31];
               nxt_q.status[ulx_pkg::FLAG_N] = q_ff.nlong[31];
               nxt_q.status[ulx_pkg::FLAG_C] = 1'b0;
               nxt_q.inhibit = 1'b0;
               nxt_q.pc = q_ff.pc + q_ff.nlen;
            end
         end
         default: begin
            nxt_q.fsm = S_IDLE;
         end
      endcase
      nxt_q.done  = fin;
      nxt_q.ready = nxt_q.fsm == S_IDLE;
   end

   // ***************************************************************
   // state register
   // ***************************************************************
   always_ff @(posedge clock) begin
      if (sys_rst) begin
         q_ff       <= '0;
         q_ff.fsm   <= S_IDLE;
         q_ff.sp    <= SP_RESET;
         q_ff.pc    <= PC_RESET;
         q_ff.ready <= 1'b1;
      end else begin
         q_ff <= nxt_q;
      end
   end

   // outputs straight from the state register
   assign instr_ready = q_ff.ready;
   assign instr_done  = q_ff.done;
   assign irq_inhibit = q_ff.inhibit;
   assign rd_data     = q_ff.rdata;
   assign pc          = q_ff.pc;
   assign sp          = q_ff.sp;
   assign status_word = q_ff.status;

endmodule : ulx_exec

// ---- design/ulx_pkg.sv ----
// Summary of operation
// - word negate: two's complement, flags except sticky
// - byte negate: two's complement, flags except sticky
// - long normalize shifts left until top set
// - normalize stops at 31 shifts, sets zero unless top then set
// - word invert: Z N set, C V cleared
// - byte invert: Z N set, C V cleared
// - word OR of addressed source into destination
// - byte OR of source into destination byte
// - pop word into destination, sp plus two
// - pop-all: first word to mask1/window pair
// - pop flags loads status/mask pair, sp plus two
// - push: sp minus two, then store word
// - push flags stores pair, clears status word
// - no interrupt call right after push flags
// - return loads pc from stack, sp plus two
package ulx_pkg;

   // ***************************************************************
   // opcodes and addressing
   // ***************************************************************
   localparam logic [7:0] OP_WORD_NEGATE    = 8'h03;
   localparam logic [7:0] OP_BYTE_NEGATE    = 8'h13;
   localparam logic [7:0] OP_LONG_NORMALIZE = 8'h0F;
   localparam logic [7:0] OP_WORD_INVERT    = 8'h02;
   localparam logic [7:0] OP_BYTE_INVERT    = 8'h12;
   localparam logic [7:0] OP_WORD_OR        = 8'h80;
   localparam logic [7:0] OP_BYTE_OR        = 8'h90;
   localparam logic [7:0] OP_POP_WORD       = 8'hCC;
   localparam logic [7:0] OP_PUSH_WORD      = 8'hC8;
   localparam logic [7:0] OP_POP_ALL        = 8'hF5;
   localparam logic [7:0] OP_PUSH_ALL       = 8'hF4;
   localparam logic [7:0] OP_POP_FLAGS      = 8'hF3;
   localparam logic [7:0] OP_PUSH_FLAGS     = 8'hF2;
   localparam logic [7:0] OP_RETURN         = 8'hF0;
   localparam logic [7:0] OP_NOP            = 8'hFD;
   localparam logic [7:0] OP_MODE_MASK      = 8'hFC;
   localparam logic [1:0] MODE_IMMEDIATE    = 2'h1;

   // ***************************************************************
   // status word bits, stack and normalize figures
   // ***************************************************************
   localparam int          FLAG_Z       = 7;
   localparam int          FLAG_N       = 6;
   localparam int          FLAG_V       = 5;
   localparam int          FLAG_TRAP    = 4;
   localparam int          FLAG_C       = 3;
   localparam int          FLAG_STICKY  = 0;
   localparam logic [15:0] STACK_STEP   = 16'h0002;
   localparam logic [4:0]  NORM_MAX     = 5'h1F;
   localparam logic [7:0]  STATUS_CLEAR = 8'h00;

   // ***************************************************************
   // register port map
   // ***************************************************************
   localparam logic [7:0] ADDR_REG_LIMIT = 8'h80;
   localparam logic [7:0] ADDR_SP        = 8'hF0;
   localparam logic [7:0] ADDR_PC        = 8'hF2;
   localparam logic [7:0] ADDR_STATUS    = 8'hF4;
   localparam logic [7:0] ADDR_MASK1     = 8'hF6;
   localparam logic [7:0] ADDR_STATE     = 8'hF8;

   typedef enum logic [3:0] {
      K_NOP, K_WNEG, K_BNEG, K_NORM, K_WINV, K_BINV, K_WOR, K_BOR,
      K_POP, K_PUSH, K_POPALL, K_PUSHALL, K_POPFLG, K_PUSHFLG, K_RETURN
   } ulx_kind_t;

   typedef struct packed {
      logic [7:0]  opcode;
      logic [7:0]  opnd_a;
      logic [7:0]  opnd_b;
      logic [15:0] imm;
   } ulx_instr_t;

   typedef struct packed {
      logic [7:0]  addr;
      logic [15:0] wdata;
      logic        wr;
      logic        rd;
   } ulx_regbus_t;

endpackage : ulx_pkg

// ---- dv/ulx_exec_chk.sv ----
`timescale 1ns/10ps
module ulx_exec_chk (
   // clock and reset
   input wire logic                 clock,
   input wire logic                 sys_rst,
   // instruction stream
   input wire logic                 instr_valid,
   input wire ulx_pkg::ulx_instr_t  instr,
   input wire logic                 instr_ready,
   input wire logic                 instr_done,
   input wire logic                 irq_inhibit,
   // register port
   input wire ulx_pkg::ulx_regbus_t regbus,
   input wire logic [15:0]          rd_data,
   // core state view
   input wire logic [15:0]          pc,
   input wire logic [15:0]          sp,
   input wire logic [7:0]           status_word
);
   // ***************************************************************
   // accepted instruction decode
   // ***************************************************************
   default clocking cb @(posedge clock); endclocking
   default disable iff (sys_rst);
   // one accept term keeps every antecedent tied to the handshake
   wire       acc = instr_valid && instr_ready;
   wire [7:0] op  = instr.opcode;
   wire [7:0] opm = instr.opcode & ulx_pkg::OP_MODE_MASK;

   chk_norm_busy: assert property (acc && op == ulx_pkg::OP_LONG_NORMALIZE |=> !instr_ready)
      else $error("normalize did not hold off the instruction port");
   chk_done_single: assert property (acc && op != ulx_pkg::OP_LONG_NORMALIZE |=> instr_done)
      else $error("single cycle instruction gave no done pulse");
   chk_pop_sp: assert property (acc && opm == ulx_pkg::OP_POP_WORD
      |=> sp == $past(sp) + ulx_pkg::STACK_STEP && $stable(status_word)) else $error("pop word stack step wrong");
   chk_push_sp: assert property (acc && opm == ulx_pkg::OP_PUSH_WORD
      |=> sp == $past(sp) - ulx_pkg::STACK_STEP && $stable(status_word)) else $error("push word stack step wrong");
   chk_ret_sp: assert property (acc && op == ulx_pkg::OP_RETURN
      |=> sp == $past(sp) + ulx_pkg::STACK_STEP && $stable(status_word)) else $error("return stack step wrong");
   chk_flag_push: assert property (acc && op == ulx_pkg::OP_PUSH_FLAGS
      |=> status_word == ulx_pkg::STATUS_CLEAR && sp == $past(sp) - 16'h0002) else $error("push flags wrong");
   chk_push_inhibit: assert property (acc && op == ulx_pkg::OP_PUSH_FLAGS |=> irq_inhibit)
      else $error("interrupt not held off after push flags");
   chk_pop_inhibit: assert property (acc && op == ulx_pkg::OP_POP_FLAGS
      |=> irq_inhibit && sp == $past(sp) + 16'h0002) else $error("pop flags wrong");
   chk_all_push: assert property (acc && op == ulx_pkg::OP_PUSH_ALL
      |=> sp == $past(sp) - 16'h0004 && status_word == 8'h00) else $error("push all wrong");
   chk_all_pop: assert property (acc && op == ulx_pkg::OP_POP_ALL |=> sp == $past(sp) + 16'h0004)
      else $error("pop all stack step wrong");
   chk_nop_pc: assert property (acc && op == ulx_pkg::OP_NOP
      |=> pc == $past(pc) + 16'h0001 && $stable(sp) && $stable(status_word)) else $error("no-op changed state");
endmodule : ulx_exec_chk

bind ulx_exec ulx_exec_chk i_ulx_exec_chk (.clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid),
   .instr(instr), .instr_ready(instr_ready), .instr_done(instr_done), .irq_inhibit(irq_inhibit),
   .regbus(regbus), .rd_data(rd_data), .pc(pc), .sp(sp), .status_word(status_word));

// ---- dv/ulx_exec_tb_top.sv ----
`timescale 1ns/10ps
`define CHK(nm, ex, ac) begin n_checks++; if ((ac) !== (ex)) begin \
   $display("CHECK FAILED %s expected %h seen %h", nm, ex, ac); err_total++; end end
module ulx_exec_tb_top;
   // ***************************************************************
   // stimulus and design
   // ***************************************************************
   logic                 clock       = 1'b0;
   logic                 sys_rst     = 1'b1;
   logic                 instr_valid = 1'b0;
   ulx_pkg::ulx_instr_t  instr       = '0;
   ulx_pkg::ulx_regbus_t regbus      = '0;
   logic                 instr_ready, instr_done, irq_inhibit;
   logic [15:0]          rd_data, pc, sp;
   logic [7:0]           status_word;
   int                   err_total   = 0;
   int                   n_checks    = 0;

   always #4 clock = ~clock;

   ulx_exec i_ulx_exec (.clock(clock), .sys_rst(sys_rst), .instr_valid(instr_valid), .instr(instr),
      .instr_ready(instr_ready), .instr_done(instr_done), .irq_inhibit(irq_inhibit), .regbus(regbus),
      .rd_data(rd_data), .pc(pc), .sp(sp), .status_word(status_word));

   // ***************************************************************
   // access tasks
   // ***************************************************************
   // one idle cycle after each strobe so no signal is driven twice in a step
   task automatic wr(input logic [7:0] a, input logic [15:0] d);
      @(posedge clock);
      regbus <= '{a, d, 1'b1, 1'b0};
      @(posedge clock);
      regbus <= '0;
   endtask : wr

   task automatic rd(input string nm, input logic [7:0] a, input logic [15:0] ex);
      @(posedge clock);
      regbus <= '{a, 16'h0000, 1'b0, 1'b1};
      @(posedge clock);
      regbus <= '0;
      #1;
      `CHK(nm, ex, rd_data)
   endtask : rd

   // waits on the done pulse under a bound; normalize takes up to 33 cycles
   task automatic ex(input logic [7:0] o, input logic [7:0] a, input logic [7:0] b, input logic [15:0] im);
      int n;
      @(posedge clock);
      instr_valid <= 1'b1;
      instr       <= '{o, a, b, im};
      @(posedge clock);
      instr_valid <= 1'b0;
      for (n = 0; n < 60; n++) begin
         #1;
         if (instr_done === 1'b1) break;
         @(posedge clock);
      end
      if (n == 60) `CHK("done", 1'b1, instr_done)
   endtask : ex

   task automatic end_of_test();
      if (err_total == 0 && n_checks > 0) $display("*** PASS ***");
      else $display("*** FAIL ***");
      $finish;
   endtask : end_of_test

   // ***************************************************************
   // scenarios
   // ***************************************************************
   initial begin
      repeat (8) @(posedge clock);
      sys_rst <= 1'b0;
      rd("sp", 8'hF0, 16'h0040);
      rd("unmapped", 8'h90, 16'h0000);
      // negate with sticky preset: plain value, then the overflow edge
      wr(8'hF4, 16'h0100);
      wr(8'h10, 16'h0005);
      ex(8'h03, 8'h10, 8'h00, 16'h0000);
      rd("neg", 8'h10, 16'hFFFB);
      `CHK("neg flags", 8'h41, status_word)
      wr(8'h10, 16'h8000);
      ex(8'h03, 8'h10, 8'h00, 16'h0000);
      rd("neg ovf", 8'h10, 16'h8000);
      `CHK("neg ovf flags", 8'h71, status_word)
      // byte negate of zero sets carry and keeps the high byte
      wr(8'h20, 16'h1200);
      ex(8'h13, 8'h20, 8'h00, 16'h0000);
      rd("byte_negate_op", 8'h20, 16'h1200);
      `CHK("byte_negate_op flags", 8'h99, status_word)
      ex(8'h02, 8'h10, 8'h00, 16'h0000);
      rd("not", 8'h10, 16'h7FFF);
      `CHK("not flags", 8'h11, status_word)
      ex(8'h12, 8'h20, 8'h00, 16'h0000);
      rd("byte_invert_op", 8'h20, 16'h12FF);
      `CHK("byte_invert_op flags", 8'h51, status_word)
      // or in register and immediate modes
      wr(8'h30, 16'h8000);
      ex(8'h80, 8'h30, 8'h10, 16'h0000);
      rd("or reg", 8'h10, 16'hFFFF);
      ex(8'h81, 8'h00, 8'h30, 16'h0F00);
      rd("or imm", 8'h30, 16'h8F00);
      ex(8'h91, 8'h0F, 8'h21, 16'h0000);
      rd("orb imm", 8'h20, 16'h1FFF);
      // normalize: fifteen shifts, then an all-zero operand
      wr(8'h40, 16'h0000);
      wr(8'h42, 16'h0001);
      ex(8'h0F, 8'h50, 8'h40, 16'h0000);
      rd("norm hi", 8'h42, 16'h8000);
      rd("norm cnt", 8'h50, 16'h000F);
      wr(8'h42, 16'h0000);
      ex(8'h0F, 8'h50, 8'h40, 16'h0000);
      rd("norm zero cnt", 8'h50, 16'h001F);
      `CHK("norm zero flag", 1'b1, status_word[7])
      // push register and immediate, pop back
      ex(8'hC8, 8'h10, 8'h00, 16'h0000);
      ex(8'hC9, 8'h00, 8'h00, 16'hABCD);
      `CHK("push sp", 16'h003C, sp)
      ex(8'hCC, 8'h60, 8'h00, 16'h0000);
      rd("pop", 8'h60, 16'hABCD);
      ex(8'hCC, 8'h62, 8'h00, 16'h0000);
      rd("pop first", 8'h62, 16'hFFFF);
      // flag push clears the status word, flag pop restores the pair
      wr(8'hF4, 16'h5A3C);
      ex(8'hF2, 8'h00, 8'h00, 16'h0000);
      `CHK("push_flags_op status", 8'h00, status_word)
      `CHK("push_flags_op inhibit", 1'b1, irq_inhibit)
      ex(8'hF3, 8'h00, 8'h00, 16'h0000);
      rd("pop_flags_op pair", 8'hF4, 16'h5A3C);
      `CHK("pop_flags_op inhibit", 1'b1, irq_inhibit)
      // push-all then pop-all after both pairs were wiped
      wr(8'hF6, 16'h0755);
      wr(8'hF4, 16'h1234);
      ex(8'hF4, 8'h00, 8'h00, 16'h0000);
      `CHK("inhibit clear", 1'b0, irq_inhibit)
      wr(8'hF6, 16'h0000);
      wr(8'hF4, 16'h0000);
      ex(8'hF5, 8'h00, 8'h00, 16'h0000);
      rd("pop_all_op mask", 8'hF6, 16'h0755);
      rd("pop_all_op status", 8'hF4, 16'h1234);
      `CHK("pop_all_op sp", 16'h0040, sp)
      // return lands on the pushed address, no-op only steps it
      ex(8'hC9, 8'h00, 8'h00, 16'h0123);
      ex(8'hF0, 8'h00, 8'h00, 16'h0000);
      `CHK("ret pc", 16'h0123, pc)
      `CHK("ret sp", 16'h0040, sp)
      ex(8'hFD, 8'h00, 8'h00, 16'h0000);
      rd("nop pc", 8'hF2, 16'h0124);
      end_of_test();
   end

   // watchdog well beyond the roughly 160 cycles the tests need
   initial begin
      #200000;
      err_total++;
      end_of_test();
   end
endmodule : ulx_exec_tb_top
